/* core/occ_defines.vh */
// constants shared by the compare channel control files
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// --------------------
// register word offsets (byte address bits 7:0)
// --------------------
`define OCC_ADDR_CON2 8'h00
`define OCC_ADDR_CON1 8'h04
`define OCC_ADDR_PRIM 8'h08
`define OCC_ADDR_SEC 8'h0C
`define OCC_ADDR_PER 8'h10
`define OCC_ADDR_CNT 8'h14

// --------------------
// control two fields
// --------------------
`define OCC_C2_PERSIST 15
`define OCC_C2_FLEVEL 14
`define OCC_C2_FDIR 13
`define OCC_C2_INV 12
`define OCC_C2_DCB_HI 10
`define OCC_C2_DCB_LO 9
`define OCC_C2_CASC 8
`define OCC_C2_TRIG 7
`define OCC_C2_TSTAT 6
`define OCC_C2_TRIS 5
`define OCC_C2_SRC_HI 4
`define OCC_C2_SRC_LO 0
`define OCC_C2_WMASK 16'hF7FF
`define OCC_C2_RESET 16'h000C

// --------------------
// control one fields
// --------------------
`define OCC_C1_FEN 7
`define OCC_C1_FSTAT 4
`define OCC_C1_TCLR 3
`define OCC_C1_MODE_HI 2
`define OCC_C1_MODE_LO 0
`define OCC_C1_WMASK 16'h008F
`define OCC_C1_RESET 16'h0000

// --------------------
// compare modes and source codes
// --------------------
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_SS_HIGH 3'h1
`define OCC_MODE_SS_LOW 3'h2
`define OCC_MODE_TOGGLE 3'h3
`define OCC_MODE_DBL_ONE 3'h4
`define OCC_MODE_DBL_CONT 3'h5
`define OCC_MODE_PWM_EDGE 3'h6
`define OCC_MODE_PWM_CTR 3'h7
`define OCC_SRC_NONE 5'h00
`define OCC_SRC_RSV_A 5'h10
`define OCC_SRC_RSV_B 5'h11
`define OCC_SRC_SELF 5'h1F

// --------------------
// timing and bus constants
// --------------------
`define OCC_TICK_LAST 2'h3
`define OCC_HALF_MASK 32'h0000_FFFF
`define OCC_HSIZE_WORD 3'h2
`define OCC_HRESP_OKAY 1'b0
`define OCC_ZERO16 16'h0000
`define OCC_ZERO32 32'h0000_0000
`define OCC_ONE32 32'h0000_0001

`endif

/* core/occ_fine_delay.v */
// falling-edge fine delay of the compare waveform in quarter instruction cycles
`include "occ_defines.vh"

module occ_fine_delay (
    input wire clk,
    input wire reset,
    input wire rawIn,
    input wire [1:0] delaySel,
    output reg delayedOut
);

    reg [2:0] hist_q;

    // --------------------
    // history of the waveform, one clock per quarter cycle
    // --------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            hist_q <= 3'h0;
        end else begin
            hist_q <= {hist_q[1:0], rawIn};
        end
    end

    // rising edge passes at once, falling edge waits for the history to drain
    always @* begin
        case (delaySel)
            2'h0: delayedOut = rawIn;
            2'h1: delayedOut = rawIn | hist_q[0];
            2'h2: delayedOut = rawIn | hist_q[0] | hist_q[1];
            2'h3: delayedOut = rawIn | (|hist_q);
            default: delayedOut = rawIn;
        endcase
    end

endmodule

/* core/occ_channel_ctrl.v */
// compare/pwm channel with its second control register and ahb-lite slave
//
// What this block does
// - persist: fault ends once input gone and software clears status.
// - no persist: fault ends once input gone and a new period starts.
// - fault drives the output to the fault level.
// - force direction bit makes the pin an output on fault.
// - invert bit inverts the channel output.
// - fine delay holds the falling edge 0, 1/4, 1/2, 3/4 cycle.
// - fine delay double-buffered in pwm modes only.
// - cascade bit joins two halves into one 32-bit compare.
// - trigger select: start on trigger; else sync time base to source.
// - hardware sets trigger flag; timer held clear while it is 0.
// - high impedance bit releases the pin; clear connects the output.
// - source field picks channels, timers, captures, comparators, converter.
// - source code zero runs unsynchronised.
// - trigger clear mode clears the flag on secondary compare match.
// - in pwm modes duty values latch only on period match once running; while stopped or outside pwm modes they follow the live registers.
// - fault enable and status act only in pwm modes.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`include "occ_defines.vh"

module occ_channel_ctrl (
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire faultPin,
    input wire [31:0] sourceEvents,
    output reg pinOut,
    output reg pinOutEnable,
    output reg timerTriggered,
    output reg periodMatch,
    output reg cascadeActive
);

    // --------------------
    // helper functions
    // --------------------
    // keep only the low half unless the pair is cascaded
    function [31:0] fitWidth;
        input casc;
        input [31:0] v;
        begin
            fitWidth = casc ? v : (v & `OCC_HALF_MASK);
        end
    endfunction

    // apply a software write under a mask of writable bits
    function [15:0] maskWrite;
        input [15:0] old;
        input [15:0] wr;
        input [15:0] msk;
        begin
            maskWrite = (old & ~msk) | (wr & msk);
        end
    endfunction

    // --------------------
    // state
    // --------------------
    reg [15:0] con2_q, con2_d;
    reg [15:0] con1_q, con1_d;
    reg [31:0] primCmp_q, primCmp_d;
    reg [31:0] secCmp_q, secCmp_d;
    reg [31:0] period_q, period_d;
    reg [31:0] count_q, count_d;
    reg [1:0] tick_q, tick_d;
    reg [31:0] primAct_q, primAct_d;
    reg [31:0] secAct_q, secAct_d;
    reg [1:0] dcbAct_q, dcbAct_d;
    reg wave_q, wave_d;
    reg shotDone_q, shotDone_d;
    reg faultActive_q, faultActive_d;
    reg faultSync1_q, faultSync2_q;
    reg wrPend_q, rdPend_q;
    reg [7:0] addr_q;
    reg pinOut_d, pinOe_d;

    // --------------------
    // decoded control fields
    // --------------------
    wire [2:0] mode = con1_q[`OCC_C1_MODE_HI:`OCC_C1_MODE_LO];
    wire pwmMode = (mode == `OCC_MODE_PWM_EDGE) || (mode == `OCC_MODE_PWM_CTR);
    wire casc = con2_q[`OCC_C2_CASC];
    wire trigger_clear_mode = con2_q[`OCC_C2_TRIG];
    wire timer_triggered_flag = con2_q[`OCC_C2_TSTAT];
    wire [4:0] srcSel = con2_q[`OCC_C2_SRC_HI:`OCC_C2_SRC_LO];
    wire [1:0] dcbReg = con2_q[`OCC_C2_DCB_HI:`OCC_C2_DCB_LO];

    // bus write strobes for the data phase
    wire wrCon2 = wrPend_q && (addr_q == `OCC_ADDR_CON2);
    wire wrCon1 = wrPend_q && (addr_q == `OCC_ADDR_CON1);
    wire wrPrim = wrPend_q && (addr_q == `OCC_ADDR_PRIM);
    wire wrSec = wrPend_q && (addr_q == `OCC_ADDR_SEC);
    wire wrPer = wrPend_q && (addr_q == `OCC_ADDR_PER);
    wire accept = hsel && htrans[1] && hready && (hsize == `OCC_HSIZE_WORD);

    // --------------------
    // source selection
    // --------------------
    // reserved codes and the self code never fire; self loops would lock up
    wire srcValid = (srcSel != `OCC_SRC_NONE) && (srcSel != `OCC_SRC_RSV_A) &&
                    (srcSel != `OCC_SRC_RSV_B) && (srcSel != `OCC_SRC_SELF);
    wire srcHit = srcValid && sourceEvents[srcSel];

    // --------------------
    // time base comparisons
    // --------------------
    wire running = (mode != `OCC_MODE_OFF) && (!trigger_clear_mode || timer_triggered_flag);
    wire tickNow = (tick_q == `OCC_TICK_LAST);
    wire [31:0] cnt = fitWidth(casc, count_q);
    wire [31:0] perUse = fitWidth(casc, period_q);
    wire [31:0] primUse = fitWidth(casc, pwmMode ? primAct_q : primCmp_q);
    wire [31:0] secUse = fitWidth(casc, pwmMode ? secAct_q : secCmp_q);
    wire perHit = running && tickNow && (cnt == perUse);
    wire primHit = running && tickNow && (cnt == primUse);
    wire secHit = running && tickNow && (cnt == secUse);

    // fault input counts only when enabled and in a pwm mode
    wire faultIn = faultSync2_q && con1_q[`OCC_C1_FEN] && pwmMode;

    // fine delay source: buffered copy in pwm modes, live field elsewhere
    wire [1:0] dcbUse = pwmMode ? dcbAct_q : dcbReg;
    wire delayed;

    occ_fine_delay uDelay (
        .clk(clk),
        .reset(reset),
        .rawIn(wave_q),
        .delaySel(dcbUse),
        .delayedOut(delayed)
    );

    // --------------------
    // register read mux
    // --------------------
    reg [31:0] readValue;
    always @* begin
        case (addr_q)
            `OCC_ADDR_CON2: readValue = {`OCC_ZERO16, con2_q};
            `OCC_ADDR_CON1: readValue = {`OCC_ZERO16, con1_q};
            `OCC_ADDR_PRIM: readValue = primCmp_q;
            `OCC_ADDR_SEC: readValue = secCmp_q;
            `OCC_ADDR_PER: readValue = period_q;
            `OCC_ADDR_CNT: readValue = cnt;
            default: readValue = `OCC_ZERO32;
        endcase
    end

    // --------------------
    // control registers and flags
    // --------------------
    // hardware set beats every clear in the same cycle
    always @* begin
        con2_d = con2_q;
        con1_d = con1_q;
        primCmp_d = wrPrim ? hwdata : primCmp_q;
        secCmp_d = wrSec ? hwdata : secCmp_q;
        period_d = wrPer ? hwdata : period_q;
        if (wrCon2) begin
            con2_d = maskWrite(con2_q, hwdata[15:0], `OCC_C2_WMASK);
        end else if (con1_q[`OCC_C1_TCLR] && secHit) begin
            con2_d[`OCC_C2_TSTAT] = 1'b0;
        end
        if (trigger_clear_mode && srcHit) begin
            con2_d[`OCC_C2_TSTAT] = 1'b1;
        end
        if (wrCon1) begin
            con1_d = maskWrite(con1_q, hwdata[15:0], `OCC_C1_WMASK);
            // status takes only a clearing write; a one leaves it alone
            con1_d[`OCC_C1_FSTAT] = con1_q[`OCC_C1_FSTAT] & hwdata[`OCC_C1_FSTAT];
        end
        if (faultIn) begin
            con1_d[`OCC_C1_FSTAT] = 1'b1;
        end
    end

    // --------------------
    // time base and double buffer
    // --------------------
    always @* begin
        tick_d = running ? tick_q + 2'h1 : 2'h0;
        count_d = count_q;
        if (!running) begin
            count_d = `OCC_ZERO32;
        end else if (!trigger_clear_mode && srcHit) begin
            count_d = `OCC_ZERO32;
        end else if (tickNow) begin
            count_d = perHit ? `OCC_ZERO32 : fitWidth(casc, cnt + `OCC_ONE32);
        end
        // live values until running or outside pwm modes, then only at the end of a period
        primAct_d = primAct_q;
        secAct_d = secAct_q;
        dcbAct_d = dcbAct_q;
        if (!running || perHit || !pwmMode) begin
            primAct_d = primCmp_q;
            secAct_d = secCmp_q;
            dcbAct_d = dcbReg;
        end
    end

    // --------------------
    // compare waveform
    // --------------------
    always @* begin
        wave_d = wave_q;
        shotDone_d = shotDone_q;
        case (mode)
            `OCC_MODE_OFF: wave_d = 1'b0;
            `OCC_MODE_SS_HIGH: begin
                if (primHit) begin
                    wave_d = 1'b1;
                end
            end
            `OCC_MODE_SS_LOW: begin
                if (primHit) begin
                    wave_d = 1'b0;
                end
            end
            `OCC_MODE_TOGGLE: begin
                if (primHit) begin
                    wave_d = ~wave_q;
                end
            end
            `OCC_MODE_DBL_ONE: begin
                if (!shotDone_q && primHit) begin
                    wave_d = 1'b1;
                end else if (!shotDone_q && secHit) begin
                    wave_d = 1'b0;
                    shotDone_d = 1'b1;
                end
            end
            `OCC_MODE_DBL_CONT: begin
                if (primHit) begin
                    wave_d = 1'b1;
                end else if (secHit) begin
                    wave_d = 1'b0;
                end
            end
            // secondary above period gives a steady high level
            `OCC_MODE_PWM_EDGE: wave_d = running && (cnt < secUse);
            `OCC_MODE_PWM_CTR: wave_d = running && (cnt >= primUse) && (cnt < secUse);
            default: wave_d = 1'b0;
        endcase
        // a mode write restarts the one-shot from its documented level
        if (wrCon1) begin
            wave_d = (hwdata[`OCC_C1_MODE_HI:`OCC_C1_MODE_LO] == `OCC_MODE_SS_LOW);
            shotDone_d = 1'b0;
        end
    end

    // --------------------
    // fault state and pin drive
    // --------------------
    always @* begin
        faultActive_d = faultActive_q;
        if (faultIn) begin
            faultActive_d = 1'b1;
        end else if (faultActive_q && con2_q[`OCC_C2_PERSIST]) begin
            // held until software has cleared the latched status
            faultActive_d = con1_d[`OCC_C1_FSTAT];
        end else if (faultActive_q && (perHit || !pwmMode)) begin
            faultActive_d = 1'b0;
        end
        pinOut_d = delayed ^ con2_q[`OCC_C2_INV];
        if (faultActive_d) begin
            pinOut_d = con2_q[`OCC_C2_FLEVEL];
        end
        pinOe_d = !con2_q[`OCC_C2_TRIS];
        if (faultActive_d && con2_q[`OCC_C2_FDIR]) begin
            pinOe_d = 1'b1;
        end
    end

    // --------------------
    // fault pin synchroniser
    // --------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            faultSync1_q <= 1'b0;
            faultSync2_q <= 1'b0;
        end else begin
            faultSync1_q <= faultPin;
            faultSync2_q <= faultSync1_q;
        end
    end

    // --------------------
    // ahb-lite slave: zero-wait writes, one wait state on reads
    // --------------------
    // the read wait lets a write in the preceding data phase land first
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata <= `OCC_ZERO32;
            hreadyout <= 1'b1;
            hresp <= `OCC_HRESP_OKAY;
        end else begin
            hresp <= `OCC_HRESP_OKAY;
            wrPend_q <= 1'b0;
            if (rdPend_q) begin
                hrdata <= readValue;
                hreadyout <= 1'b1;
                rdPend_q <= 1'b0;
            end else if (accept) begin
                addr_q <= haddr[7:0];
                wrPend_q <= hwrite;
                rdPend_q <= !hwrite;
                hreadyout <= hwrite;
            end
        end
    end

    // --------------------
    // channel state registers
    // --------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            con2_q <= `OCC_C2_RESET;
            con1_q <= `OCC_C1_RESET;
            primCmp_q <= `OCC_ZERO32;
            secCmp_q <= `OCC_ZERO32;
            period_q <= `OCC_ZERO32;
            count_q <= `OCC_ZERO32;
            tick_q <= 2'h0;
            primAct_q <= `OCC_ZERO32;
            secAct_q <= `OCC_ZERO32;
            dcbAct_q <= 2'h0;
            wave_q <= 1'b0;
            shotDone_q <= 1'b0;
            faultActive_q <= 1'b0;
            pinOut <= 1'b0;
            pinOutEnable <= 1'b1;
            timerTriggered <= 1'b0;
            periodMatch <= 1'b0;
            cascadeActive <= 1'b0;
        end else begin
            con2_q <= con2_d;
            con1_q <= con1_d;
            primCmp_q <= primCmp_d;
            secCmp_q <= secCmp_d;
            period_q <= period_d;
            count_q <= count_d;
            tick_q <= tick_d;
            primAct_q <= primAct_d;
            secAct_q <= secAct_d;
            dcbAct_q <= dcbAct_d;
            wave_q <= wave_d;
            shotDone_q <= shotDone_d;
            faultActive_q <= faultActive_d;
            pinOut <= pinOut_d;
            pinOutEnable <= pinOe_d;
            timerTriggered <= con2_d[`OCC_C2_TSTAT];
            periodMatch <= perHit;
            cascadeActive <= casc;
        end
    end

endmodule

/* tb/occ_event_source.sv */
// model of the on-chip timers, captures and channels that feed source events
`include "occ_defines.vh"

module occ_event_source (
    input wire clk,
    input wire reset,
    input wire fire,
    input wire [4:0] code,
    input wire [3:0] lag,
    output logic [31:0] sourceEvents
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] wait_q;
    logic [5:0] tick_q;

    // --------------------
    // event pulses
    // --------------------
    // pulse after a chosen lag; a free channel 2 event keeps an unselected source busy
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_q <= 5'h00;
            tick_q <= 6'h00;
            sourceEvents <= `OCC_ZERO32;
        end else begin
            tick_q <= tick_q + 6'h01;
            wait_q <= fire ? {1'b0, lag} + 5'h01 : (wait_q != 5'h00 ? wait_q - 5'h01 : 5'h00);
            sourceEvents <= (wait_q == 5'h01 ? `OCC_ONE32 << code : `OCC_ZERO32)
                | (tick_q == 6'h00 && code != 5'h02 ? 32'h0000_0004 : `OCC_ZERO32);
        end
    end
endmodule

/* tb/occ_channel_ctrl_checker.sv */
// concurrent checks on the compare channel ports
`include "occ_defines.vh"

module occ_channel_ctrl_checker (
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire faultPin,
    input wire [31:0] sourceEvents,
    input wire pinOut,
    input wire pinOutEnable,
    input wire timerTriggered,
    input wire periodMatch,
    input wire cascadeActive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrC2_q, wrC1_q;
    logic [15:0] c2Data_q, c1Data_q;
    logic [3:0] since_q, faultRun_q;
    wire acc = hsel && htrans[1] && hready && hsize == `OCC_HSIZE_WORD;
    wire [4:0] src = c2Data_q[4:0];
    wire srcOk = src != 5'h00 && src != 5'h10 && src != 5'h11 && src != 5'h1F;
    wire fltArm = c1Data_q[7] && c1Data_q[2:1] == 2'h3 && faultRun_q == 4'h8;

    // --------------------
    // shadow of written controls
    // --------------------
    // saturating counters fire the cascade, tri-state and fault antecedents once
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wrC2_q <= 1'b0;
            wrC1_q <= 1'b0;
            c2Data_q <= `OCC_C2_RESET;
            c1Data_q <= `OCC_C1_RESET;
            since_q <= 4'hF;
            faultRun_q <= 4'h0;
        end else begin
            wrC2_q <= acc && hwrite && haddr[7:0] == `OCC_ADDR_CON2;
            wrC1_q <= acc && hwrite && haddr[7:0] == `OCC_ADDR_CON1;
            if (wrC2_q) c2Data_q <= hwdata[15:0];
            if (wrC1_q) c1Data_q <= hwdata[15:0];
            since_q <= wrC2_q ? 4'h0 : (since_q != 4'hF ? since_q + 4'h1 : since_q);
            faultRun_q <= !faultPin ? 4'h0 : (faultRun_q != 4'h9 ? faultRun_q + 4'h1 : faultRun_q);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_okay; hresp == `OCC_HRESP_OKAY; endproperty
    property p_rd; acc && !hwrite |=> s_rd_wait; endproperty
    property p_wr; acc && hwrite |=> hreadyout; endproperty
    property p_casc; since_q == 4'h2 |-> cascadeActive == c2Data_q[8]; endproperty
    property p_pm; periodMatch |=> !periodMatch [*3]; endproperty
    property p_flevel; fltArm |-> pinOut == c2Data_q[14]; endproperty
    property p_fdir; fltArm && c2Data_q[13] |-> pinOutEnable; endproperty
    property p_tris; since_q == 4'h3 && !c1Data_q[7] |-> pinOutEnable == !c2Data_q[5]; endproperty
    property p_trig; c2Data_q[7] && since_q > 4'h3 && srcOk && sourceEvents[src] |-> ##[1:2] timerTriggered;
    endproperty

    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd: assert property (p_rd) else $error("read wait cycle wrong");
    a_wr: assert property (p_wr) else $error("write stalled");
    a_casc: assert property (p_casc) else $error("cascade state wrong");
    a_pm: assert property (p_pm) else $error("period match too close");
    a_flevel: assert property (p_flevel) else $error("fault level wrong");
    a_fdir: assert property (p_fdir) else $error("fault direction not forced");
    a_tris: assert property (p_tris) else $error("pin enable wrong");
    a_trig: assert property (p_trig) else $error("trigger flag not set");
endmodule

bind occ_channel_ctrl occ_channel_ctrl_checker chk_i (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .faultPin(faultPin), .sourceEvents(sourceEvents), .pinOut(pinOut),
    .pinOutEnable(pinOutEnable), .timerTriggered(timerTriggered), .periodMatch(periodMatch),
    .cascadeActive(cascadeActive));

/* tb/occ_channel_ctrl_test.sv */
// self-checking bench of the compare channel second control logic
`include "occ_defines.vh"

module occ_channel_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, hsel = 0, hwrite = 0, faultPin = 0, fire = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, sourceEvents;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = `OCC_HSIZE_WORD;
    logic [4:0] code = 0;
    logic [3:0] lag = 0;
    logic hreadyout, hresp, pinOut, pinOutEnable, timerTriggered, periodMatch, cascadeActive;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    int regs [0:5];

    always #25 clk = ~clk;

    occ_channel_ctrl dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .faultPin(faultPin), .sourceEvents(sourceEvents),
        .pinOut(pinOut), .pinOutEnable(pinOutEnable), .timerTriggered(timerTriggered),
        .periodMatch(periodMatch), .cascadeActive(cascadeActive));
    occ_event_source src (.clk(clk), .reset(reset), .fire(fire), .code(code), .lag(lag),
        .sourceEvents(sourceEvents));

    // --------------------
    // helpers
    // --------------------
    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one word transfer, waiting on hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // write and keep the register model in step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1, a, d, r);
        case (a)
            `OCC_ADDR_CON2: regs[0] = d & 32'h0000_F7FF;
            `OCC_ADDR_CON1: regs[1] = (d & 32'h0000_008F) | (d & regs[1] & 32'h0000_0010);
            `OCC_ADDR_CNT: ;
            default: if (a < 8'h14) regs[a >> 2] = d;
        endcase
    endtask

    task automatic rdc(input string nm, input logic [7:0] a);
        logic [31:0] r;
        bus(0, a, 0, r);
        chk(nm, r, a < 8'h18 ? regs[a >> 2] : 0);
    endtask

    task automatic highs(output int n, output int p);
        n = 0;
        p = 0;
        repeat (64) begin
            @(posedge clk);
            n += (pinOut === 1'b1);
            p += (periodMatch === 1'b1);
        end
    endtask

    // cycle ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // --------------------
    // main sequence
    // --------------------
    initial begin
        int n, p;
        logic [31:0] r;
        regs = '{32'h0000_000C, 0, 0, 0, 0, 0};
        n = $urandom(32'h0000_9FE2);
        repeat (2) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rdc("con2 reset", `OCC_ADDR_CON2);
        rdc("con1 reset", `OCC_ADDR_CON1);
        wr(`OCC_ADDR_CNT, 32'h0000_1234);
        wr(8'h3C, 32'h0000_5555);
        rdc("count read only", `OCC_ADDR_CNT);
        rdc("unmapped", 8'h3C);
        // random controls, trigger bits off
        repeat (6) begin
            wr(`OCC_ADDR_CON2, $urandom & 32'h0000_FF3F);
            rdc("con2 rw", `OCC_ADDR_CON2);
            chk("cascade", cascadeActive, regs[0][8]);
            chk("pin enable", pinOutEnable, !regs[0][5]);
        end
        // edge pwm: 8 ticks of 4 clocks, high 3 ticks plus fine delay
        wr(`OCC_ADDR_PER, 32'h0000_0007);
        wr(`OCC_ADDR_SEC, 32'h0000_0003);
        rdc("period", `OCC_ADDR_PER);
        wr(`OCC_ADDR_CON1, `OCC_MODE_PWM_EDGE);
        for (int i = 0; i < 5; i++) begin
            wr(`OCC_ADDR_CON2, {19'h0_0000, i[2], 1'b0, i[1:0], 9'h000});
            repeat (80) @(posedge clk);
            highs(n, p);
            chk("high clocks", n, i == 4 ? 64 - 24 : 24 + 2 * i);
            chk("period matches", p, 2);
        end
        // centre pwm, inverted: high while 1 <= count < 3
        wr(`OCC_ADDR_PRIM, 32'h0000_0001);
        wr(`OCC_ADDR_CON1, `OCC_MODE_PWM_CTR);
        repeat (80) @(posedge clk);
        highs(n, p);
        chk("centre high clocks", n, 64 - 16);
        // persistent fault, high level, forced out of tri-state
        wr(`OCC_ADDR_CON2, 32'h0000_E020);
        wr(`OCC_ADDR_CON1, 32'h0000_0086);
        faultPin <= 1;
        repeat (10) @(posedge clk);
        chk("fault level", pinOut, 1);
        chk("fault drive", pinOutEnable, 1);
        faultPin <= 0;
        repeat (80) @(posedge clk);
        chk("fault held", pinOutEnable, 1);
        regs[1] |= 32'h0000_0010;
        rdc("fault status", `OCC_ADDR_CON1);
        wr(`OCC_ADDR_CON1, 32'h0000_0086);
        repeat (80) @(posedge clk);
        chk("fault left", pinOutEnable, 0);
        // non-persistent fault, low level
        wr(`OCC_ADDR_CON2, 32'h0000_2020);
        faultPin <= 1;
        repeat (10) @(posedge clk);
        chk("fault low", pinOut, 0);
        faultPin <= 0;
        repeat (50) @(posedge clk);
        chk("fault ends", pinOutEnable, 0);
        // fault ignored outside the pwm modes
        wr(`OCC_ADDR_CON1, 32'h0000_0085);
        faultPin <= 1;
        repeat (10) @(posedge clk);
        chk("fault ignored", pinOutEnable, 0);
        rdc("no status", `OCC_ADDR_CON1);
        faultPin <= 0;
        // trigger from capture 1; the timer waits held at zero
        wr(`OCC_ADDR_PER, 32'h0000_0100);
        wr(`OCC_ADDR_CON1, 32'h0000_0006);
        wr(`OCC_ADDR_CON2, 32'h0000_0094); // capture source used only as a trigger
        rdc("count held", `OCC_ADDR_CNT);
        code <= 5'h14;
        lag <= 4'($urandom_range(7, 0));
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        repeat (24) @(posedge clk);
        chk("trigger flag", timerTriggered, 1);
        bus(0, `OCC_ADDR_CNT, 0, r);
        chk("count runs", r != 0, 1);
        regs[0] |= 32'h0000_0040;
        rdc("flag reads", `OCC_ADDR_CON2);
        wr(`OCC_ADDR_CON1, 32'h0000_000E);
        repeat (1100) @(posedge clk);
        regs[0] &= 32'hFFFF_FFBF;
        rdc("flag cleared", `OCC_ADDR_CON2);
        rdc("count held", `OCC_ADDR_CNT);
        // sync to timer 3: its event restarts the running count
        wr(`OCC_ADDR_CON1, 32'h0000_0006);
        wr(`OCC_ADDR_CON2, 32'h0000_000D); // a timer, never this channel
        repeat (200) @(posedge clk);
        code <= 5'h0D;
        lag <= 4'h0;
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        repeat (3) @(posedge clk);
        bus(0, `OCC_ADDR_CNT, 0, r);
        chk("synced count", r < 32'h0000_0004, 1);
        conclude();
    end
endmodule
